// >>> verilog/lbsp_map.svh
// register offsets, field positions, reset values and sizes of the local slave unit
`ifndef LBSP_MAP_SVH
`define LBSP_MAP_SVH

// register byte offsets on the ahb-lite slave
`define LBSP_OFF_MISC_CONTROL_REG   8'h00
`define LBSP_OFF_MISC_CONTROL2_REG  8'h04
`define LBSP_OFF_IRQ_STAT   8'h08
`define LBSP_OFF_IRQ_EN     8'h0C
`define LBSP_OFF_IRQ_ROUTE  8'h10
`define LBSP_OFF_FIFO_STAT  8'h14

// field positions
`define LBSP_BIT_PAR_SENSE  0
`define LBSP_BIT_PERR       0
`define LBSP_BIT_IRQ_EN     0
`define LBSP_BIT_IRQ_ROUTE  0

// reset values
`define LBSP_RST_PAR_SENSE  1'b0
`define LBSP_RST_IRQ_EN     1'b0
`define LBSP_RST_IRQ_ROUTE  1'b0

// bus role codes latched from the size strap
`define LBSP_ROLE_STRAP0    2'b00
`define LBSP_ROLE_STRAP1    2'b01

// posted write fifo and read buffer sizes
`define LBSP_PWF_DEPTH      64
`define LBSP_PWF_AW         6
`define LBSP_RPB_DEPTH      8
`define LBSP_RPB_AW         3

`endif

// >>> verilog/lbsp_pkg.sv
// types shared by the local slave unit
package lbsp_pkg;

   // one local bus slave cycle as seen on the pins
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  be;
      logic [3:0]  par;
      logic        wr;
   } lbsp_lb_req_t;

   // one posted write fifo entry
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  be;
      logic        delayed;
   } lbsp_wentry_t;

   // one pci master transaction request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  be;
      logic        wr;
   } lbsp_pci_req_t;

   // local slave states, gray along idle-dwait-rwait-ack
   typedef enum logic [1:0] {
      LS_IDLE  = 2'b00,
      LS_DWAIT = 2'b01,
      LS_RWAIT = 2'b11,
      LS_ACK   = 2'b10
   } lbsp_ls_state_t;

   // pci master states
   typedef enum logic [0:0] {
      PM_IDLE = 1'b0,
      PM_BUSY = 1'b1
   } lbsp_pm_state_t;

   // owner of the current pci transaction
   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_FIFO = 2'b01,
      SRC_READ = 2'b11,
      SRC_DMA  = 2'b10
   } lbsp_src_t;

endpackage

// >>> verilog/lbsp_slave_unit.sv
// local bus slave unit: lane parity, posted write fifo, read buffer, shared pci master
`include "lbsp_map.svh"

module lbsp_slave_unit
   import lbsp_pkg::*;
(
   // clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // ahb-lite register slave
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   // reset strap
   input  wire logic          size_strap_bit,
   // local bus slave cycle
   input  wire logic          lb_start,
   input  wire lbsp_lb_req_t  lb_req,
   input  wire logic          posted_write_enable,
   output logic               lb_ack,
   output logic [31:0]        lb_rdata,
   output logic               lb_data_oe,
   output logic [3:0]         lane_parity_pins_o,
   output logic               lane_parity_pins_oe,
   // pci master transaction port
   output logic               pci_valid,
   output lbsp_pci_req_t      pci_req,
   output logic               pci_par,
   input  wire logic          pci_done,
   input  wire logic [31:0]   pci_rdata,
   // dma channel request
   input  wire logic          dma_req,
   input  wire lbsp_pci_req_t dma_cmd,
   output logic               dma_gnt,
   output logic               dma_done,
   output logic [31:0]        dma_rdata,
   // interrupt pins
   output logic               pci_irq_out,
   output logic               local_irq_out
);

   // ************************************************************
   // helper functions
   // ************************************************************

   // per-lane parity bit; odd flips the even result
   function automatic logic [3:0] lane_par(input logic [31:0] d, input logic odd);
      logic [3:0] p;
      p = 4'h0;
      for (int i = 0; i < 4; i++) begin
         p[i] = ^d[8*i +: 8] ^ odd;
      end
      return p;
   endfunction

   // pci parity covers data and byte enables, even, never the local sense
   function automatic logic pci_parity(input lbsp_pci_req_t r);
      return ^{r.data, r.be};
   endfunction

   // ************************************************************
   // declarations
   // ************************************************************

   logic [1:0]                 role_q;
   logic                       strap_done_q;
   logic                       sense_q;
   logic                       perr_q;
   logic                       irq_en_q;
   logic                       irq_route_q;
   logic                       ph_q;
   logic                       ready_q;
   logic [7:0]                 a_q;
   logic                       w_q;
   logic [31:0]                hrdata_q;
   logic                       reg_wr;
   logic                       acc;
   lbsp_wentry_t               pwf_mem [`LBSP_PWF_DEPTH];
   logic [`LBSP_PWF_AW:0]      wp_q;
   logic [`LBSP_PWF_AW:0]      rp_q;
   logic [`LBSP_PWF_AW:0]      fill;
   logic                       full;
   logic                       empty;
   logic [31:0]                rpb_mem [`LBSP_RPB_DEPTH];
   lbsp_ls_state_t             ls_q;
   logic                       dw_pend_q;
   logic                       rd_req_q;
   logic [31:0]                rd_addr_q;
   logic [3:0]                 rd_be_q;
   logic                       wr_take;
   logic                       perr_set;
   logic                       ack_q;
   logic [31:0]                lb_rdata_q;
   logic                       data_oe_q;
   logic [3:0]                 par_out_q;
   logic                       par_oe_q;
   lbsp_pm_state_t             pm_q;
   lbsp_src_t                  src_q;
   lbsp_src_t                  pick;
   logic                       rr_q;
   logic                       pci_valid_q;
   lbsp_pci_req_t              pci_req_q;
   logic                       pci_par_q;
   logic                       dw_done_q;
   logic                       rd_done_q;
   logic                       dma_gnt_q;
   logic                       dma_done_q;
   logic [31:0]                dma_rdata_q;
   logic                       pci_irq_q;
   logic                       local_irq_q;

   // ************************************************************
   // reset strap and bus role
   // ************************************************************

   // caught once on the first edge after release, never under reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         role_q       <= `LBSP_ROLE_STRAP0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         role_q       <= size_strap_bit ? `LBSP_ROLE_STRAP1 : `LBSP_ROLE_STRAP0;
         strap_done_q <= 1'b1;
      end
   end

   // ************************************************************
   // ahb-lite slave, one wait state on every access
   // ************************************************************

   assign acc    = hsel & hready & htrans[1];
   assign reg_wr = ph_q & w_q;

   // address phase latch; the wait state lets the read mux see hwdata effects
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_q    <= 1'b0;
         ready_q <= 1'b1;
         a_q     <= 8'h00;
         w_q     <= 1'b0;
      end else if (ph_q) begin
         ph_q    <= 1'b0;
         ready_q <= 1'b1;
      end else if (acc) begin
         ph_q    <= 1'b1;
         ready_q <= 1'b0;
         a_q     <= haddr[7:0];
         w_q     <= hwrite;
      end
   end

   // read mux; unmapped offsets read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (ph_q && !w_q) begin
         unique case (a_q)
            `LBSP_OFF_MISC_CONTROL_REG:   hrdata_q <= {30'h0000_0000, role_q};
            `LBSP_OFF_MISC_CONTROL2_REG:  hrdata_q <= {31'h0000_0000, sense_q};
            `LBSP_OFF_IRQ_STAT:   hrdata_q <= {31'h0000_0000, perr_q};
            `LBSP_OFF_IRQ_EN:     hrdata_q <= {31'h0000_0000, irq_en_q};
            `LBSP_OFF_IRQ_ROUTE:  hrdata_q <= {31'h0000_0000, irq_route_q};
            `LBSP_OFF_FIFO_STAT:  hrdata_q <= {21'h00_0000, fill, full, empty, dw_pend_q, rd_req_q};
            default:              hrdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign hreadyout = ready_q;
   assign hrdata    = hrdata_q;
   assign hresp     = 1'b0;

   // ************************************************************
   // control registers
   // ************************************************************

   // parity sense, enable and route
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sense_q     <= `LBSP_RST_PAR_SENSE;
         irq_en_q    <= `LBSP_RST_IRQ_EN;
         irq_route_q <= `LBSP_RST_IRQ_ROUTE;
      end else if (reg_wr) begin
         if (a_q == `LBSP_OFF_MISC_CONTROL2_REG) sense_q <= hwdata[`LBSP_BIT_PAR_SENSE];
         if (a_q == `LBSP_OFF_IRQ_EN) irq_en_q <= hwdata[`LBSP_BIT_IRQ_EN];
         if (a_q == `LBSP_OFF_IRQ_ROUTE) irq_route_q <= hwdata[`LBSP_BIT_IRQ_ROUTE];
      end
   end

   // error flag: a new error wins over a same-cycle write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         perr_q <= 1'b0;
      end else if (perr_set) begin
         perr_q <= 1'b1;
      end else if (reg_wr && a_q == `LBSP_OFF_IRQ_STAT && hwdata[`LBSP_BIT_PERR]) begin
         perr_q <= 1'b0;
      end
   end

   // interrupt outputs, routed by a single bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pci_irq_q   <= 1'b0;
         local_irq_q <= 1'b0;
      end else begin
         pci_irq_q   <= perr_q & irq_en_q & ~irq_route_q;
         local_irq_q <= perr_q & irq_en_q & irq_route_q;
      end
   end

   assign pci_irq_out   = pci_irq_q;
   assign local_irq_out = local_irq_q;

   // ************************************************************
   // posted write fifo
   // ************************************************************

   assign fill  = wp_q - rp_q;
   assign empty = (wp_q == rp_q);
   assign full  = (wp_q[`LBSP_PWF_AW] != rp_q[`LBSP_PWF_AW]) &&
                  (wp_q[`LBSP_PWF_AW-1:0] == rp_q[`LBSP_PWF_AW-1:0]);

   // a write is taken only with room and no delayed write outstanding
   assign wr_take  = (ls_q == LS_IDLE) & lb_start & lb_req.wr & ~full & ~dw_pend_q;
   // only enabled lanes are compared
   assign perr_set = wr_take & |(lb_req.be & (lb_req.par ^ lane_par(lb_req.data, sense_q)));

   // fill side; data is stored unchanged even on a parity error
   always_ff @(posedge hclk) begin
      if (wr_take) begin
         pwf_mem[wp_q[`LBSP_PWF_AW-1:0]] <= '{addr: lb_req.addr, data: lb_req.data,
                                             be: lb_req.be, delayed: ~posted_write_enable};
      end
   end

   // pointers; pop happens when pci finishes the head entry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (wr_take) wp_q <= wp_q + 1'b1;
         if (pm_q == PM_BUSY && pci_done && src_q == SRC_FIFO) rp_q <= rp_q + 1'b1;
      end
   end

   // ************************************************************
   // local bus slave cycle engine
   // ************************************************************

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ls_q       <= LS_IDLE;
         dw_pend_q  <= 1'b0;
         rd_req_q   <= 1'b0;
         rd_addr_q  <= 32'h0000_0000;
         rd_be_q    <= 4'h0;
         ack_q      <= 1'b0;
         lb_rdata_q <= 32'h0000_0000;
         data_oe_q  <= 1'b0;
         par_out_q  <= 4'h0;
         par_oe_q   <= 1'b0;
      end else begin
         unique case (ls_q)
            LS_IDLE: begin
               if (wr_take && posted_write_enable) begin
                  ack_q <= 1'b1;
                  ls_q  <= LS_ACK;
               end else if (wr_take) begin
                  dw_pend_q <= 1'b1;
                  ls_q      <= LS_DWAIT;
               end else if (lb_start && !lb_req.wr) begin
                  rd_req_q  <= 1'b1;
                  rd_addr_q <= lb_req.addr;
                  rd_be_q   <= lb_req.be;
                  ls_q      <= LS_RWAIT;
               end
            end
            LS_DWAIT: begin
               // ack only after pci has taken the delayed write
               if (dw_done_q) begin
                  dw_pend_q <= 1'b0;
                  ack_q     <= 1'b1;
                  ls_q      <= LS_ACK;
               end
            end
            LS_RWAIT: begin
               if (rd_done_q) begin
                  rd_req_q   <= 1'b0;
                  ack_q      <= 1'b1;
                  lb_rdata_q <= rpb_mem[rd_addr_q[`LBSP_RPB_AW+1:2]];
                  par_out_q  <= lane_par(rpb_mem[rd_addr_q[`LBSP_RPB_AW+1:2]], sense_q);
                  data_oe_q  <= 1'b1;
                  par_oe_q   <= 1'b1;
                  ls_q       <= LS_ACK;
               end
            end
            LS_ACK: begin
               ack_q     <= 1'b0;
               data_oe_q <= 1'b0;
               par_oe_q  <= 1'b0;
               ls_q      <= LS_IDLE;
            end
         endcase
      end
   end

   assign lb_ack              = ack_q;
   assign lb_rdata            = lb_rdata_q;
   assign lb_data_oe          = data_oe_q;
   assign lane_parity_pins_o  = par_out_q;
   assign lane_parity_pins_oe = par_oe_q;

   // ************************************************************
   // shared pci master and arbiter
   // ************************************************************

   // fifo drains before a read so writes stay ordered; dma alternates
   always_comb begin
      pick = SRC_NONE;
      if (rr_q && dma_req && !dma_done_q) begin
         pick = SRC_DMA;
      end else if (!empty) begin
         pick = SRC_FIFO;
      end else if (rd_req_q && !rd_done_q) begin
         pick = SRC_READ;
      end else if (dma_req && !dma_done_q) begin
         pick = SRC_DMA;
      end
   end

   // read buffer fill from returned pci data
   always_ff @(posedge hclk) begin
      if (pm_q == PM_BUSY && pci_done && src_q == SRC_READ) begin
         rpb_mem[rd_addr_q[`LBSP_RPB_AW+1:2]] <= pci_rdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pm_q        <= PM_IDLE;
         src_q       <= SRC_NONE;
         rr_q        <= 1'b0;
         pci_valid_q <= 1'b0;
         pci_req_q   <= '0;
         pci_par_q   <= 1'b0;
         dw_done_q   <= 1'b0;
         rd_done_q   <= 1'b0;
         dma_gnt_q   <= 1'b0;
         dma_done_q  <= 1'b0;
         dma_rdata_q <= 32'h0000_0000;
      end else begin
         dw_done_q  <= 1'b0;
         rd_done_q  <= 1'b0;
         dma_done_q <= 1'b0;
         unique case (pm_q)
            PM_IDLE: begin
               if (pick != SRC_NONE) begin
                  // one owner per transaction
                  src_q       <= pick;
                  pci_valid_q <= 1'b1;
                  pm_q        <= PM_BUSY;
                  unique case (pick)
                     SRC_FIFO: begin
                        pci_req_q <= '{addr: pwf_mem[rp_q[`LBSP_PWF_AW-1:0]].addr,
                                       data: pwf_mem[rp_q[`LBSP_PWF_AW-1:0]].data,
                                       be: pwf_mem[rp_q[`LBSP_PWF_AW-1:0]].be, wr: 1'b1};
                        pci_par_q <= pci_parity('{addr: 32'h0000_0000,
                                       data: pwf_mem[rp_q[`LBSP_PWF_AW-1:0]].data,
                                       be: pwf_mem[rp_q[`LBSP_PWF_AW-1:0]].be, wr: 1'b1});
                     end
                     SRC_READ: begin
                        pci_req_q <= '{addr: rd_addr_q, data: 32'h0000_0000,
                                       be: rd_be_q, wr: 1'b0};
                        pci_par_q <= pci_parity('{addr: 32'h0000_0000, data: 32'h0000_0000,
                                       be: rd_be_q, wr: 1'b0});
                     end
                     default: begin
                        pci_req_q <= dma_cmd;
                        pci_par_q <= pci_parity(dma_cmd);
                        dma_gnt_q <= 1'b1;
                     end
                  endcase
               end
            end
            PM_BUSY: begin
               if (pci_done) begin
                  pci_valid_q <= 1'b0;
                  pm_q        <= PM_IDLE;
                  src_q       <= SRC_NONE;
                  rr_q        <= (src_q != SRC_DMA);
                  if (src_q == SRC_FIFO) dw_done_q <= pwf_mem[rp_q[`LBSP_PWF_AW-1:0]].delayed;
                  if (src_q == SRC_READ) rd_done_q <= 1'b1;
                  if (src_q == SRC_DMA) begin
                     dma_gnt_q   <= 1'b0;
                     dma_done_q  <= 1'b1;
                     dma_rdata_q <= pci_rdata;
                  end
               end
            end
         endcase
      end
   end

   assign pci_valid = pci_valid_q;
   assign pci_req   = pci_req_q;
   assign pci_par   = pci_par_q;
   assign dma_gnt   = dma_gnt_q;
   assign dma_done  = dma_done_q;
   assign dma_rdata = dma_rdata_q;

endmodule // lbsp_slave_unit

// >>> dv/lbsp_slave_unit_properties.sv
// concurrent checks on the ports of the local slave unit
module lbsp_unit_chk
   import lbsp_pkg::*;
(
   // clock and reset
   input wire logic          hclk,
   input wire logic          hresetn,
   // local bus
   input wire logic          lb_start,
   input wire lbsp_lb_req_t  lb_req,
   input wire logic          posted_write_enable,
   input wire logic          lb_ack,
   input wire logic [31:0]   lb_rdata,
   input wire logic          lb_data_oe,
   input wire logic [3:0]    lane_parity_pins_o,
   input wire logic          lane_parity_pins_oe,
   // pci side and interrupts
   input wire logic          pci_valid,
   input wire lbsp_pci_req_t pci_req,
   input wire logic          pci_par,
   input wire logic          pci_done,
   input wire logic          pci_irq_out,
   input wire logic          local_irq_out
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0] lane_sum;
   // ones count of each byte plus its bit, all alike for one sense
   assign lane_sum = {^{lb_rdata[31:24], lane_parity_pins_o[3]}, ^{lb_rdata[23:16],
      lane_parity_pins_o[2]}, ^{lb_rdata[15:8], lane_parity_pins_o[1]},
      ^{lb_rdata[7:0], lane_parity_pins_o[0]}};
   property p_ack_pulse; lb_ack |=> !lb_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than a cycle");
   property p_rd_drive; lb_ack && !lb_req.wr |-> lb_data_oe && lane_parity_pins_oe; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
   property p_lane; lane_parity_pins_oe |-> lane_sum == 4'h0 || lane_sum == 4'hf; endproperty
   a_lane: assert property (p_lane) else $error("lane parity mixed");
   property p_pci_par; pci_valid |-> pci_par == ^{pci_req.data, pci_req.be}; endproperty
   a_pci_par: assert property (p_pci_par) else $error("pci parity bad");
   property p_pci_hold; pci_valid && !pci_done |=> pci_valid && $stable(pci_req); endproperty
   a_pci_hold: assert property (p_pci_hold) else $error("pci request moved");
   property p_pci_drop; pci_valid && pci_done |-> ##[1:2] !pci_valid; endproperty
   a_pci_drop: assert property (p_pci_drop) else $error("pci valid stuck");
   property p_irq_one; !(pci_irq_out && local_irq_out); endproperty
   a_irq_one: assert property (p_irq_one) else $error("both irq pins high");
   // reads and delayed writes answer only after the pci side finished
   property p_wait_pci;
      lb_ack && !(lb_req.wr && posted_write_enable) |-> $past(pci_done, 2);
   endproperty
   a_wait_pci: assert property (p_wait_pci) else $error("early ack");
endmodule // lbsp_unit_chk

bind lbsp_slave_unit lbsp_unit_chk lbsp_unit_chk_i (.hclk, .hresetn, .lb_start, .lb_req,
   .posted_write_enable, .lb_ack, .lb_rdata, .lb_data_oe, .lane_parity_pins_o,
   .lane_parity_pins_oe, .pci_valid, .pci_req, .pci_par, .pci_done, .pci_irq_out,
   .local_irq_out);

// >>> dv/lbsp_pci_model.sv
// behavioural pci target answering the unit's master port
module lbsp_pci_model
   import lbsp_pkg::*;
#(
   parameter int DELAY = 3
)
(
   // clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // master port of the unit
   input  wire logic          pci_valid,
   input  wire lbsp_pci_req_t pci_req,
   input  wire logic          pci_par,
   output logic               pci_done,
   output logic [31:0]        pci_rdata,
   // observations for the bench
   output logic [7:0]         wr_cnt,
   output logic [31:0]        last_wdata,
   output logic [7:0]         par_errs
);
   // ****************************************
   // target
   // ****************************************
   logic [3:0] wait_q;
   logic       served_q; // done given, waiting for valid to fall
   // read data toggles outside the done cycle so a stale sample shows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {pci_done, pci_rdata, wr_cnt, last_wdata, par_errs, wait_q, served_q} <= '0;
      end else begin
         pci_done <= 1'b0;
         pci_rdata <= ~pci_rdata;
         if (!pci_valid) begin
            served_q <= 1'b0;
            wait_q <= 4'h0;
         end else if (!served_q) begin
            if (pci_par !== ^{pci_req.data, pci_req.be}) par_errs <= par_errs + 8'h01;
            wait_q <= wait_q + 4'h1;
            if (wait_q == DELAY[3:0]) begin
               pci_done <= 1'b1;
               served_q <= 1'b1;
               pci_rdata <= pci_req.addr ^ 32'hc3c3_0f0f;
               if (pci_req.wr) begin
                  wr_cnt <= wr_cnt + 8'h01;
                  last_wdata <= pci_req.data;
               end
            end
         end
      end
   end
endmodule // lbsp_pci_model

// >>> dv/tb_top.sv
// self-checking bench of the local slave unit
module tb_top;
   import lbsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, size_strap_bit, lb_start, lb_ack;
   logic posted_write_enable, lb_data_oe, lane_parity_pins_oe, pci_valid, pci_par, pci_done;
   logic dma_req, pci_irq_out, local_irq_out, dma_done;
   logic [31:0] haddr, hwdata, hrdata, lb_rdata, pci_rdata, last_wdata, rd, dma_rdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  lane_parity_pins_o, rp;
   logic [7:0]  wr_cnt, par_errs;
   lbsp_lb_req_t  lb_req;
   lbsp_pci_req_t pci_req, dma_cmd;
   int failures = 0;
   int compares = 0;
   // ****************************************
   // harness
   // ****************************************
   lbsp_slave_unit lbsp_slave_unit_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .size_strap_bit, .lb_start,
      .lb_req, .posted_write_enable, .lb_ack, .lb_rdata, .lb_data_oe, .lane_parity_pins_o,
      .lane_parity_pins_oe, .pci_valid, .pci_req, .pci_par, .pci_done, .pci_rdata, .dma_req,
      .dma_cmd, .dma_gnt(), .dma_done, .dma_rdata, .pci_irq_out, .local_irq_out);
   lbsp_pci_model lbsp_pci_model_i (.hclk, .hresetn, .pci_valid, .pci_req, .pci_par,
      .pci_done, .pci_rdata, .wr_cnt, .last_wdata, .par_errs);
   // free running bus clock
   always #5 hclk = ~hclk;
   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded wait for a high sample at a rising edge
   task automatic wait_hi(ref logic sig);
      int n;
      n = 0;
      @(posedge hclk);
      while (sig !== 1'b1) begin
         n++;
         if (n > 300) begin
            failures++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_hi(hreadyout);
      htrans <= 2'b00;
      hwdata <= wd;
      wait_hi(hreadyout);
      rd = hrdata;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0000_0000);
      check(n, rd, e);
   endtask
   // parity bits of a word for the chosen sense
   function automatic logic [3:0] lpar(input logic [31:0] d, input logic odd);
      for (int i = 0; i < 4; i++) lpar[i] = ^d[8*i+:8] ^ odd;
   endfunction
   task automatic lb(input logic wr, input logic pwe, input logic [31:0] d,
                     input logic [3:0] be, input logic [3:0] par);
      lb_req <= '{addr: 32'h0000_0010, data: d, be: be, par: par, wr: wr};
      posted_write_enable <= pwe;
      lb_start <= 1'b1;
      wait_hi(lb_ack);
      rd = lb_rdata;
      rp = lane_parity_pins_o;
      lb_start <= 1'b0;
      @(posedge hclk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      rchk("bus role", 8'h00, 32'h0000_0001);
      ahb(1'b1, 8'h00, 32'h0000_0000);
      rchk("bus role kept", 8'h00, 32'h0000_0001);
      rchk("parity sense", 8'h04, 32'h0000_0000);
      rchk("flag reset", 8'h08, 32'h0000_0000);
      rchk("unmapped", 8'h18, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_perr();
      int n;
      ahb(1'b1, 8'h10, 32'h0000_0001);
      ahb(1'b1, 8'h0c, 32'h0000_0001);
      lb(1'b1, 1'b1, 32'h8000_00ff, 4'b0001, lpar(32'h8000_00ff, 1'b0) ^ 4'b1110);
      rchk("flag idle lanes", 8'h08, 32'h0000_0000);
      lb(1'b1, 1'b1, 32'h8000_00ff, 4'b1000, lpar(32'h8000_00ff, 1'b0) ^ 4'b1000);
      rchk("flag set", 8'h08, 32'h0000_0001);
      check("local irq", {31'h0, local_irq_out}, 32'h0000_0001);
      ahb(1'b1, 8'h10, 32'h0000_0000);
      ahb(1'b1, 8'h08, 32'h0000_0000);
      check("pci irq", {31'h0, pci_irq_out}, 32'h0000_0001);
      rchk("flag kept", 8'h08, 32'h0000_0001);
      ahb(1'b1, 8'h08, 32'h0000_0001);
      rchk("flag cleared", 8'h08, 32'h0000_0000);
      check("irq removed", {31'h0, pci_irq_out}, 32'h0000_0000);
      for (n = 0; n < 50 && wr_cnt !== 8'h02; n++) @(posedge hclk);
      check("forwarded count", {24'h00_0000, wr_cnt}, 32'h0000_0002);
      check("forwarded data", last_wdata, 32'h8000_00ff);
      check("pci parity", {24'h00_0000, par_errs}, 32'h0000_0000);
      $display("test parity error done");
   endtask
   task automatic t_read();
      for (int odd = 0; odd < 2; odd++) begin
         ahb(1'b1, 8'h04, 32'(odd));
         lb(1'b0, 1'b1, 32'h0000_0000, 4'b1111, 4'h0);
         check("read data", rd, 32'h0000_0010 ^ 32'hc3c3_0f0f);
         check("read parity", {28'h000_0000, rp}, {28'h000_0000, lpar(rd, odd[0])});
      end
      dma_cmd <= '{32'h0000_0020, 32'h0000_0000, 4'hf, 1'b0};
      dma_req <= 1'b1;
      wait_hi(dma_done);
      dma_req <= 1'b0;
      check("dma data", dma_rdata, 32'hc3c3_0f2f);
      ahb(1'b1, 8'h04, 32'h0000_0000);
      $display("test read done");
   endtask
   task automatic t_delayed();
      logic [7:0] c0;
      c0 = wr_cnt;
      lb(1'b1, 1'b0, 32'h1234_5678, 4'b1111, lpar(32'h1234_5678, 1'b0));
      check("delayed done first", {24'h00_0000, wr_cnt}, {24'h00_0000, c0 + 8'h01});
      $display("test delayed write done");
   endtask
   // reset, then the scenarios in turn
   initial begin
      {hclk, hresetn, haddr, htrans, hwrite, hwdata, lb_start, lb_req, dma_req, dma_cmd} = '0;
      hsel = 1'b1;
      hsize = 3'h2;
      size_strap_bit = 1'b1;
      posted_write_enable = 1'b1;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_regs();
      t_perr();
      t_read();
      t_delayed();
      summarize();
   end
endmodule // tb_top
